/* diag_defines.svh */
// offsets, bit positions, reset values and codes of the diagnosis encoder
// assumes byte addresses on a 32-bit apb bus, one register per word
`ifndef DIAG_DEFINES_SVH
`define DIAG_DEFINES_SVH

// register byte offsets
`define OFF_CTRL_WORD 8'h00
`define OFF_IO_WORD 8'h04
`define OFF_GW_WORD 8'h08
`define OFF_EXT_WORD0 8'h0C
`define OFF_EXT_WORD1 8'h10
`define OFF_EXT_WORD2 8'h14
`define OFF_CONFIG 8'h18
`define OFF_MSG_HEAD 8'h1C
`define OFF_MSG_DATA 8'h20

// main controller word
`define CW_CRIT 1
`define CW_SUPPLY_A 2
`define CW_CONFIG 4
`define CW_SUPPLY_B 5
`define CW_LINK_TWO 7

// additional controller words
`define EX_CRIT 1
`define EX_SUPPLY 2
`define EX_CONFIG 4
`define EX_SUPPLY_ONE 5
`define EX_FAST_OFF 6
`define EX_SUPPLY_TWO 7
`define EX_STATE_LO 8

// i/o module word
`define IO_INTERNAL 1
`define IO_EXTERNAL 2
`define IO_HISTORY 3
`define IO_CONFIG 4
`define IO_OUT_SUPPLY 5
`define IO_DUAL_LO 8
`define IO_STATE_IN 14
`define IO_STATE_OUT 15
`define IO_TEST_LO 16
`define IO_SHORT_LO 24

// gateway word
`define GW_INTERNAL 1
`define GW_CONFIG 4
`define GW_STATE_IN 5
`define GW_STATE_OUT 6

// alarm octet and position octet
`define ALARM_INCOMING 3'h1
`define ALARM_OUTGOING 3'h2
`define POS_CONTROLLER 8'h00
`define POS_GATEWAY_ONE 8'h0D
`define IO_POS_RESET 4'h1

`endif

/* diag_pkg.sv */
// types shared by the diagnosis encoder, its checker and its bench
// assumes diag_defines.svh for all figures
package diag_pkg;

   // main controller conditions
   typedef struct packed {
      logic critical_error;
      logic supply_bad;
      logic config_bad;
      logic link_two_error;
   } ctrl_diag_t;

   // one additional controller module
   typedef struct packed {
      logic critical_error;
      logic supply_bad;
      logic config_bad;
      logic supply_input_one_bad;
      logic supply_input_two_bad;
      logic [7:0] fast_off_errors;
      logic [87:0] module_state;
   } ext_diag_t;

   // safe i/o module conditions
   typedef struct packed {
      logic internal_fail;
      logic monitor_fail;
      logic self_test_fail;
      logic poor_process_data;
      logic external_fail;
      logic history_stored;
      logic config_bad;
      logic out_supply_bad;
      logic [3:0] dual_channel_error;
      logic state_in;
      logic state_out;
      logic [7:0] test_signal_error;
      logic [3:0] short_after_high;
      logic [3:0] short_after_low;
   } io_diag_t;

   // fieldbus gateway conditions
   typedef struct packed {
      logic internal_fail;
      logic config_bad;
      logic state_in;
      logic state_out;
   } gw_diag_t;

   // source whose word is watched for alarms
   typedef enum logic [2:0] {
      SRC_CTRL,
      SRC_EXT1,
      SRC_EXT2,
      SRC_EXT3,
      SRC_IO,
      SRC_GW
   } source_t;

endpackage : diag_pkg

/* alarm_tracker.sv */
// turns changes of a watched diagnosis word between zero and nonzero into alarm octet updates
// assumes one clock; restart pulses on every write of the configuration register, even one whose source is refused
`timescale 1ns/100ps
`include "diag_defines.svh"
module alarm_tracker (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // watched word
   input wire logic [31:0] watch_word,
   input wire logic restart,
   // message fields
   output logic [7:0] alarm_octet,
   output logic [31:0] event_word,
   output logic event_pulse
);
   logic present;
   logic present_q;
   logic present_d;
   logic changed;
   logic [2:0] code_q;
   logic [2:0] code_d;
   logic [4:0] seq_q;
   logic [4:0] seq_d;
   logic [31:0] word_q;
   logic [31:0] word_d;
   logic pulse_q;

   assign present = |watch_word;
   assign changed = !restart && (present != present_q);
   // a fresh source starts from "no error" so standing errors are reported
   assign present_d = restart ? 1'b0 : present;
   assign code_d = present ? `ALARM_INCOMING : `ALARM_OUTGOING;
   assign seq_d = seq_q + 5'h01;
   assign word_d = watch_word;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         present_q <= 1'b0;
         code_q <= `ALARM_OUTGOING;
         seq_q <= 5'h00;
         word_q <= 32'h0000_0000;
         pulse_q <= 1'b0;
      end else begin
         present_q <= present_d;
         pulse_q <= changed;
         if (changed) begin
            code_q <= code_d;
            seq_q <= seq_d;
            word_q <= word_d;
         end
      end
   end

   assign alarm_octet = {seq_q, code_q};
   assign event_word = word_q;
   assign event_pulse = pulse_q;
endmodule : alarm_tracker

/* diag_encoder.sv */
// apb slave that assembles the per-module diagnosis words and a message
// assumes condition inputs synchronous to clock; zero wait state slave
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "diag_defines.svh"
module diag_encoder #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // module conditions
   input wire diag_pkg::ctrl_diag_t ctrl_diag,
   input wire diag_pkg::ext_diag_t ext1_diag,
   input wire diag_pkg::ext_diag_t ext2_diag,
   input wire diag_pkg::ext_diag_t ext3_diag,
   input wire diag_pkg::io_diag_t io_diag,
   input wire diag_pkg::gw_diag_t gw_diag,
   // message out
   output logic [7:0] msg_alarm_octet,
   output logic [7:0] msg_position,
   output logic [31:0] msg_data,
   output logic msg_pending
);

   // main controller word; untouched bits stay zero
   function automatic logic [31:0] ctrl_word(input diag_pkg::ctrl_diag_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`CW_CRIT] = c.critical_error;
      w[`CW_SUPPLY_A] = c.supply_bad;
      w[`CW_SUPPLY_B] = c.supply_bad;
      w[`CW_CONFIG] = c.config_bad;
      w[`CW_LINK_TWO] = c.link_two_error;
      return w;
   endfunction : ctrl_word

   // one function for all three extra controllers
   function automatic logic [95:0] ext_word(input diag_pkg::ext_diag_t e);
      logic [95:0] w;
      w = 96'h0;
      w[`EX_CRIT] = e.critical_error;
      w[`EX_SUPPLY] = e.supply_bad;
      w[`EX_CONFIG] = e.config_bad;
      w[`EX_SUPPLY_ONE] = e.supply_input_one_bad;
      w[`EX_FAST_OFF] = |e.fast_off_errors;
      w[`EX_SUPPLY_TWO] = e.supply_input_two_bad;
      w[95:`EX_STATE_LO] = e.module_state;
      return w;
   endfunction : ext_word

   function automatic logic [31:0] io_word(input diag_pkg::io_diag_t d);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`IO_INTERNAL] = d.internal_fail | d.monitor_fail | d.self_test_fail
         | d.poor_process_data;
      w[`IO_EXTERNAL] = d.external_fail;
      w[`IO_HISTORY] = d.history_stored;
      w[`IO_CONFIG] = d.config_bad;
      w[`IO_OUT_SUPPLY] = d.out_supply_bad;
      w[`IO_DUAL_LO+3:`IO_DUAL_LO] = d.dual_channel_error;
      w[`IO_STATE_IN] = d.state_in;
      w[`IO_STATE_OUT] = d.state_out;
      w[`IO_TEST_LO+7:`IO_TEST_LO] = d.test_signal_error;
      for (int k = 0; k < 4; k++) begin
         w[`IO_SHORT_LO+2*k] = d.short_after_high[k];
         w[`IO_SHORT_LO+2*k+1] = d.short_after_low[k];
      end
      return w;
   endfunction : io_word

   function automatic logic [31:0] gw_word(input diag_pkg::gw_diag_t g);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`GW_INTERNAL] = g.internal_fail;
      w[`GW_CONFIG] = g.config_bad;
      w[`GW_STATE_IN] = g.state_in;
      w[`GW_STATE_OUT] = g.state_out;
      return w;
   endfunction : gw_word

   // assembled words
   wire logic [31:0] ctrl_w = ctrl_word(ctrl_diag);
   wire logic [95:0] ext1_w = ext_word(ext1_diag);
   wire logic [95:0] ext2_w = ext_word(ext2_diag);
   wire logic [95:0] ext3_w = ext_word(ext3_diag);
   wire logic [31:0] io_w = io_word(io_diag);
   wire logic [31:0] gw_w = gw_word(gw_diag);

   // configuration: source [2:0], ext view [5:4], i/o pos [11:8], second gw [12]
   diag_pkg::source_t source_q;
   diag_pkg::source_t source_d;
   logic [1:0] ext_view_q;
   logic [1:0] ext_view_d;
   logic [3:0] io_pos_q;
   logic [3:0] io_pos_d;
   logic gw_second_q;
   logic gw_second_d;
   logic pending_q;
   logic pending_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // apb decode
   wire logic [7:0] byte_addr = 8'(paddr);
   wire logic setup = psel && !penable;
   wire logic access = psel && penable;
   wire logic hit_ctrl = (byte_addr == `OFF_CTRL_WORD);
   wire logic hit_io = (byte_addr == `OFF_IO_WORD);
   wire logic hit_gw = (byte_addr == `OFF_GW_WORD);
   wire logic hit_ext0 = (byte_addr == `OFF_EXT_WORD0);
   wire logic hit_ext1 = (byte_addr == `OFF_EXT_WORD1);
   wire logic hit_ext2 = (byte_addr == `OFF_EXT_WORD2);
   wire logic hit_cfg = (byte_addr == `OFF_CONFIG);
   wire logic hit_head = (byte_addr == `OFF_MSG_HEAD);
   wire logic hit_data = (byte_addr == `OFF_MSG_DATA);
   wire logic hit_any = hit_ctrl | hit_io | hit_gw | hit_ext0 | hit_ext1 | hit_ext2
      | hit_cfg | hit_head | hit_data;
   // writes to read-only words are accepted and dropped, not errors
   wire logic wr_cfg = access && pwrite && hit_cfg;
   wire logic wr_head = access && pwrite && hit_head;
   wire logic src_ok = (pwdata[2:0] <= 3'(diag_pkg::SRC_GW));

   // extra controller view for the three wide registers
   wire logic [95:0] ext_view_w = (ext_view_q == 2'h1) ? ext2_w :
      (ext_view_q == 2'h2) ? ext3_w : ext1_w;

   // watched word and its position octet
   wire logic [31:0] watch_w = (source_q == diag_pkg::SRC_EXT1) ? ext1_w[31:0] :
      (source_q == diag_pkg::SRC_EXT2) ? ext2_w[31:0] :
      (source_q == diag_pkg::SRC_EXT3) ? ext3_w[31:0] :
      (source_q == diag_pkg::SRC_IO) ? io_w :
      (source_q == diag_pkg::SRC_GW) ? gw_w : ctrl_w;
   wire logic [7:0] gw_pos = `POS_GATEWAY_ONE + {7'h00, gw_second_q};
   wire logic [7:0] pos_w = (source_q == diag_pkg::SRC_IO) ? {4'h0, io_pos_q} :
      (source_q == diag_pkg::SRC_GW) ? gw_pos : `POS_CONTROLLER;

   wire logic [7:0] alarm_w;
   wire logic [31:0] event_w;
   wire logic event_w_pulse;

   alarm_tracker u_tracker (
      .clock(clock),
      .reset(reset),
      .watch_word(watch_w),
      .restart(wr_cfg),
      .alarm_octet(alarm_w),
      .event_word(event_w),
      .event_pulse(event_w_pulse)
   );

   // next-state terms
   assign source_d = (wr_cfg && src_ok) ? diag_pkg::source_t'(pwdata[2:0]) : source_q;
   assign ext_view_d = (wr_cfg && pwdata[5:4] != 2'h3) ? pwdata[5:4] : ext_view_q;
   assign io_pos_d = wr_cfg ? pwdata[11:8] : io_pos_q;
   assign gw_second_d = wr_cfg ? pwdata[12] : gw_second_q;
   // a new event wins over a clear in the same cycle
   assign pending_d = event_w_pulse ? 1'b1 : ((wr_head && pwdata[31]) ? 1'b0 : pending_q);

   // read mux, captured in the setup cycle for a registered answer
   wire logic [31:0] cfg_r = {19'h0, gw_second_q, io_pos_q, 2'h0, ext_view_q, 1'b0,
      3'(source_q)};
   wire logic [31:0] head_r = {pending_q, 15'h0, pos_w, alarm_w};
   assign prdata_d = hit_ctrl ? ctrl_w :
      hit_io ? io_w :
      hit_gw ? gw_w :
      hit_ext0 ? ext_view_w[31:0] :
      hit_ext1 ? ext_view_w[63:32] :
      hit_ext2 ? ext_view_w[95:64] :
      hit_cfg ? cfg_r :
      hit_head ? head_r :
      hit_data ? event_w : 32'h0000_0000;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         source_q <= diag_pkg::SRC_CTRL;
         ext_view_q <= 2'h0;
         io_pos_q <= `IO_POS_RESET;
         gw_second_q <= 1'b0;
         pending_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         source_q <= source_d;
         ext_view_q <= ext_view_d;
         io_pos_q <= io_pos_d;
         gw_second_q <= gw_second_d;
         pending_q <= pending_d;
         if (setup && !pwrite) begin
            prdata_q <= prdata_d;
         end
      end
   end

   // apb answer
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = access && !hit_any;

   // message fields
   assign msg_alarm_octet = alarm_w;
   assign msg_position = pos_w;
   assign msg_data = event_w;
   assign msg_pending = pending_q;

endmodule : diag_encoder

/* diag_encoder_assertions.sv */
// checker for the diagnosis encoder ports
// assumes zero wait state apb and the top ports of diag_encoder
`timescale 1ns/100ps
module diag_encoder_assertions #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // conditions
   input wire diag_pkg::ctrl_diag_t ctrl_diag,
   input wire diag_pkg::ext_diag_t ext1_diag,
   input wire diag_pkg::ext_diag_t ext2_diag,
   input wire diag_pkg::ext_diag_t ext3_diag,
   input wire diag_pkg::io_diag_t io_diag,
   input wire diag_pkg::gw_diag_t gw_diag,
   // message
   input wire logic [7:0] msg_alarm_octet,
   input wire logic [7:0] msg_position,
   input wire logic [31:0] msg_data,
   input wire logic msg_pending
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // read data is captured in the setup cycle, so compare with past inputs
   wire rd_setup = psel && !penable && !pwrite;
   wire [31:0] cw = {24'h0, ctrl_diag.link_two_error, 1'b0, ctrl_diag.supply_bad,
      ctrl_diag.config_bad, 1'b0, ctrl_diag.supply_bad, ctrl_diag.critical_error, 1'b0};
   wire [31:0] gw = {25'h0, gw_diag.state_out, gw_diag.state_in, gw_diag.config_bad,
      2'h0, gw_diag.internal_fail, 1'b0};
   wire io_int = io_diag.internal_fail | io_diag.monitor_fail | io_diag.self_test_fail
      | io_diag.poor_process_data;
   wire [23:0] iol = {io_diag.test_signal_error, io_diag.state_out, io_diag.state_in, 2'h0,
      io_diag.dual_channel_error, 2'h0, io_diag.out_supply_bad, io_diag.config_bad,
      io_diag.history_stored, io_diag.external_fail, io_int, 1'b0};
   wire [3:0] sl = io_diag.short_after_low;
   wire [3:0] sh = io_diag.short_after_high;
   wire [7:0] ios = {sl[3], sh[3], sl[2], sh[2], sl[1], sh[1], sl[0], sh[0]};
   a_ctrl_word: assert property (rd_setup && paddr == 8'h00 |=> prdata == $past(cw))
      else $error("controller word wrong");
   a_io_low: assert property (rd_setup && paddr == 8'h04 |=> prdata[23:0] == $past(iol))
      else $error("i/o word low bits wrong");
   a_io_short: assert property (rd_setup && paddr == 8'h04 |=> prdata[31:24] == $past(ios))
      else $error("i/o short bits wrong");
   a_gw_word: assert property (rd_setup && paddr == 8'h08 |=> prdata == $past(gw))
      else $error("gateway word wrong");
   a_code_legal: assert property (msg_alarm_octet[2:0] inside {3'h1, 3'h2})
      else $error("alarm code illegal");
   a_seq_step: assert property ($changed(msg_alarm_octet)
      |-> msg_alarm_octet[7:3] == 5'($past(msg_alarm_octet[7:3]) + 5'h01))
      else $error("sequence did not step by one");
   a_pending_set: assert property ($changed(msg_alarm_octet) |=> msg_pending)
      else $error("pending not set after event");
   a_data_hold: assert property ($stable(msg_alarm_octet) |-> $stable(msg_data))
      else $error("message data moved without event");
endmodule : diag_encoder_assertions

bind diag_encoder diag_encoder_assertions #(.ADDR_W(ADDR_W)) chk (
   .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ctrl_diag(ctrl_diag), .ext1_diag(ext1_diag), .ext2_diag(ext2_diag),
   .ext3_diag(ext3_diag), .io_diag(io_diag), .gw_diag(gw_diag),
   .msg_alarm_octet(msg_alarm_octet), .msg_position(msg_position),
   .msg_data(msg_data), .msg_pending(msg_pending));

/* fieldbus_master.sv */
// apb master standing in for the fieldbus master reading diagnosis
// assumes the slave answers with pready at a rising edge
`timescale 1ns/100ps
module fieldbus_master (
   // clock
   input wire logic clock,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // apb answer
   input wire logic pready
);
   initial begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      // idle bus shows no stale request
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge clock);
   endtask : xfer
endmodule : fieldbus_master

/* diag_encoder_tb_top.sv */
// self-checking bench for the diagnosis encoder
// assumes a 40 MHz clock and the hand-over register map
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module diag_encoder_tb_top;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, mpend;
   logic [7:0] paddr, mao, mpos;
   logic [31:0] pwdata, prdata, mdat;
   logic [95:0] xw;
   logic [32:0] exp_v;
   logic [32:0] q [$];
   diag_pkg::ctrl_diag_t cd = '0;
   diag_pkg::io_diag_t id = '0;
   diag_pkg::gw_diag_t gd = '0;
   diag_pkg::ext_diag_t ex [3] = '{default: '0};
   int n_errors = 0;
   int cmp_count = 0;
   always #12.5 clock = ~clock;
   diag_encoder #(.ADDR_W(8)) DUT (.clock(clock), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ctrl_diag(cd), .ext1_diag(ex[0]),
      .ext2_diag(ex[1]), .ext3_diag(ex[2]), .io_diag(id), .gw_diag(gd),
      .msg_alarm_octet(mao), .msg_position(mpos), .msg_data(mdat), .msg_pending(mpend));
   fieldbus_master host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready));
   // result watcher: oldest note against each completed read
   always @(posedge clock) begin
      if (psel && penable && pready && !pwrite) begin
         exp_v = q.pop_front();
         `CHK({pslverr, prdata}, exp_v)
         // message pins must agree with the header and data words just read
         if (paddr == 8'h1C) begin
            `CHK({mpend, 15'h0, mpos, mao}, exp_v[31:0])
         end
         if (paddr == 8'h20) begin
            `CHK(mdat, exp_v[31:0])
         end
      end
   end
   function automatic logic [31:0] io_w(diag_pkg::io_diag_t d);
      logic [31:0] w;
      w = {8'h0, d.test_signal_error, d.state_out, d.state_in, 2'h0, d.dual_channel_error,
         2'h0, d.out_supply_bad, d.config_bad, d.history_stored, d.external_fail,
         d.internal_fail | d.monitor_fail | d.self_test_fail | d.poor_process_data, 1'b0};
      for (int k = 0; k < 4; k++) begin
         w[24 + 2 * k] = d.short_after_high[k];
         w[25 + 2 * k] = d.short_after_low[k];
      end
      return w;
   endfunction : io_w
   function automatic logic [95:0] ext_w(diag_pkg::ext_diag_t d);
      return {d.module_state, d.supply_input_two_bad, |d.fast_off_errors,
         d.supply_input_one_bad, d.config_bad, 1'b0, d.supply_bad, d.critical_error, 1'b0};
   endfunction : ext_w
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      q.push_back(e);
      host.xfer(1'b0, a, 32'h0000_0000);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d);
   endtask : wr
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   initial begin
      #1000000;
      n_errors++;
      end_sim();
   end
   initial begin
      void'($urandom(17065));
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      rd(8'h18, 33'h0_0000_0100);
      rd(8'h1C, 33'h0_0000_0002);
      rd(8'h20, 33'h0_0000_0000);
      rd(8'h24, 33'h1_0000_0000);
      $display("test reset done");
      // watched source starts as the main controller
      cd <= 4'h8;
      repeat (4) @(posedge clock);
      rd(8'h1C, 33'h0_8000_0009);
      rd(8'h20, 33'h0_0000_0002);
      wr(8'h1C, 32'h8000_0000);
      rd(8'h1C, 33'h0_0000_0009);
      cd <= 4'h0;
      repeat (4) @(posedge clock);
      rd(8'h1C, 33'h0_8000_0012);
      wr(8'h1C, 32'h8000_0000);
      wr(8'h18, 32'h0000_1005);
      rd(8'h1C, 33'h0_0000_0E12);
      gd <= 4'h8;
      repeat (4) @(posedge clock);
      rd(8'h1C, 33'h0_8000_0E19);
      rd(8'h20, 33'h0_0000_0002);
      wr(8'h18, 32'h0000_0304);
      rd(8'h1C, 33'h0_8000_0319);
      // extra controller as watched source; view 3 is refused
      wr(8'h1C, 32'h8000_0000);
      wr(8'h18, 32'h0000_0032);
      rd(8'h18, 33'h0_0000_0002);
      ex[1] <= 101'h1;
      repeat (4) @(posedge clock);
      rd(8'h1C, 33'h0_8000_0021);
      rd(8'h20, 33'h0_0000_0100);
      // source 7 is refused; the restart reports the standing error again
      wr(8'h1C, 32'h8000_0000);
      wr(8'h18, 32'h0000_0007);
      rd(8'h18, 33'h0_0000_0002);
      rd(8'h1C, 33'h0_8000_0029);
      $display("test alarm done");
      for (int i = 0; i < 12; i++) begin
         cd <= 4'($urandom);
         id <= $urandom;
         gd <= 4'($urandom);
         for (int v = 0; v < 3; v++) ex[v] <= 101'({$urandom, $urandom, $urandom, $urandom});
         // the read-only controller word ignores writes
         wr(8'h00, 32'hFFFF_FFFF);
         rd(8'h00, {25'h0, cd.link_two_error, 1'b0, cd.supply_bad, cd.config_bad, 1'b0,
            cd.supply_bad, cd.critical_error, 1'b0});
         rd(8'h04, {1'b0, io_w(id)});
         rd(8'h08, {26'h0, gd.state_out, gd.state_in, gd.config_bad, 2'h0,
            gd.internal_fail, 1'b0});
         for (int v = 0; v < 3; v++) begin
            wr(8'h18, 32'(v) << 4);
            xw = ext_w(ex[v]);
            for (int k = 0; k < 3; k++) rd(8'h0C + 8'(4 * k), {1'b0, xw[32 * k +: 32]});
         end
      end
      $display("test words done");
      end_sim();
   end
endmodule : diag_encoder_tb_top
